/* verilog/secl_classifier.sv */
`timescale 1ns/1ps
module secl_classifier #(
   parameter int N_CONN = 8,
   parameter int ALT_CYC = secl_pkg::SECL_ALT_CYC,
   parameter int FLASH_CYC = secl_pkg::SECL_FLASH_CYC
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire secl_pkg::secl_fault_t fault_i,
   input wire logic [N_CONN-1:0] conn_fault_i,
   input wire logic download_done_i,
   input wire logic switch_changed_i,
   input wire logic [7:0] node_addr_i,
   input wire logic [7:0] unit_version_i,
   input wire logic clear_i,
   output secl_pkg::secl_cls_t class_o,
   output logic [N_CONN-1:0] conn_safe_o,
   output logic safety_run_o,
   output logic all_run_o,
   output logic msg_enable_o,
   output logic tool_enable_o,
   output secl_pkg::secl_ind_t ind_o,
   output secl_pkg::secl_hist_t hist_o
);
   import secl_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic noise_q, sys_q, short_q, mis_q, abort_q;
   logic [7:0] mis_node_q;
   logic alt_tick, flash_tick, alt_q, flash_q;
   logic is_short;
   secl_cls_t cls;

   secl_tick #(.PERIOD(ALT_CYC)) u_alt (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .tick_o(alt_tick)
   );

   secl_tick #(.PERIOD(FLASH_CYC)) u_flash (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .tick_o(flash_tick)
   );

   assign is_short = fault_i.out_short &&
                     (unit_version_i >= SECL_VER_SHORT_MIN);

   ////////////////////////////////////////////////////////////////////
   // sticky fault latches; clear_i has no effect, critical needs power cycle
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         noise_q <= 1'b0;
         sys_q <= 1'b0;
         short_q <= 1'b0;
      end else begin
         noise_q <= noise_q | fault_i.noise_hw;
         sys_q <= sys_q | fault_i.sys_fail |
                  (fault_i.out_short & ~is_short);
         short_q <= short_q | is_short;
      end
   end

   // switch mismatch only after completed download
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mis_q <= 1'b0;
         mis_node_q <= 8'h00;
      end else if (switch_changed_i && download_done_i && !mis_q) begin
         mis_q <= 1'b1;
         mis_node_q <= node_addr_i;
      end else if (clear_i) begin
         mis_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         abort_q <= 1'b0;
      end else begin
         abort_q <= fault_i.abort_other | (abort_q & ~clear_i);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // severity ranking
   always_comb begin
      if (noise_q || sys_q || short_q) begin
         cls = SECL_CLS_CRITICAL;
      end else if (mis_q || abort_q) begin
         cls = SECL_CLS_ABORT;
      end else if (|conn_fault_i) begin
         cls = SECL_CLS_NONFATAL;
      end else begin
         cls = SECL_CLS_NONE;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         alt_q <= 1'b0;
         flash_q <= 1'b0;
      end else begin
         alt_q <= alt_q ^ alt_tick;
         flash_q <= flash_q ^ flash_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reactions per class
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         class_o <= SECL_CLS_NONE;
         conn_safe_o <= '1;
         safety_run_o <= 1'b0;
         all_run_o <= 1'b0;
         msg_enable_o <= 1'b0;
         tool_enable_o <= 1'b0;
      end else begin
         class_o <= cls;
         unique case (cls)
            SECL_CLS_NONE, SECL_CLS_NONFATAL: begin
               conn_safe_o <= conn_fault_i;
               safety_run_o <= 1'b1;
               all_run_o <= 1'b1;
               msg_enable_o <= 1'b1;
               tool_enable_o <= 1'b1;
            end
            SECL_CLS_ABORT: begin
               conn_safe_o <= '1;
               safety_run_o <= 1'b0;
               all_run_o <= 1'b1;
               msg_enable_o <= 1'b1;
               tool_enable_o <= 1'b1;
            end
            SECL_CLS_CRITICAL: begin
               conn_safe_o <= '1;
               safety_run_o <= 1'b0;
               all_run_o <= 1'b0;
               msg_enable_o <= 1'b0;
               tool_enable_o <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // indicators and display
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ind_o <= '0;
      end else if (noise_q) begin
         ind_o <= '0;
      end else if (short_q) begin
         ind_o.module_health_indicator <= SECL_LED_RED;
         ind_o.network_health_indicator <= SECL_LED_OFF;
         ind_o.digit_left <= SECL_CH_P;
         ind_o.digit_right <= SECL_CH_6;
      end else if (sys_q) begin
         ind_o.module_health_indicator <= SECL_LED_RED;
         ind_o.network_health_indicator <= SECL_LED_OFF;
         ind_o.digit_left <= SECL_CH_H;
         ind_o.digit_right <= SECL_CH_BLANK;
      end else if (mis_q) begin
         // flashing red; E8 alternating with node
         ind_o.module_health_indicator <=
            flash_q ? SECL_LED_RED_FLASH : SECL_LED_OFF;
         ind_o.network_health_indicator <= SECL_LED_OFF;
         ind_o.digit_left <= alt_q ? {4'h0, mis_node_q[7:4]} : SECL_CH_E;
         ind_o.digit_right <= alt_q ? {4'h0, mis_node_q[3:0]} : SECL_CH_8;
      end else begin
         ind_o.module_health_indicator <= SECL_LED_GREEN;
         ind_o.network_health_indicator <= SECL_LED_GREEN;
         ind_o.digit_left <= node_addr_i[7:0] >> 4;
         ind_o.digit_right <= {4'h0, node_addr_i[3:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // history write pulses on the first sys_fail or out_short, or on a mismatch with neither latched or arriving; none while noise is latched
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hist_o <= '0;
      end else if (noise_q) begin
         hist_o <= '0;
      end else if ((fault_i.sys_fail || fault_i.out_short) &&
                   !sys_q && !short_q) begin
         hist_o <= '{wr: 1'b1, code: SECL_HIST_SYSFAIL, node: node_addr_i};
      end else if (switch_changed_i && download_done_i && !mis_q &&
                   !sys_q && !short_q) begin
         hist_o <= '{wr: 1'b1, code: SECL_HIST_SWMIS, node: node_addr_i};
      end else begin
         hist_o.wr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_abort_safe;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (cls == SECL_CLS_ABORT) |=> (!safety_run_o && &conn_safe_o);
   endproperty
   a_abort_safe: assert property (p_abort_safe)
      else $error("abort did not force safe state");
   property p_abort_msg;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (cls == SECL_CLS_ABORT) |=> (msg_enable_o && tool_enable_o);
   endproperty
   a_abort_msg: assert property (p_abort_msg)
      else $error("abort closed inspection path");
   property p_crit_stop;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (cls == SECL_CLS_CRITICAL) |=> (!all_run_o && !msg_enable_o);
   endproperty
   a_crit_stop: assert property (p_crit_stop)
      else $error("critical did not stop all functions");
   property p_nonfatal;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (cls == SECL_CLS_NONFATAL) |=>
         (safety_run_o && conn_safe_o == $past(conn_fault_i));
   endproperty
   a_nonfatal: assert property (p_nonfatal)
      else $error("nonfatal reaction wrong");
   property p_noise_dark;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      noise_q |=> (ind_o == '0 && !hist_o.wr);
   endproperty
   a_noise_dark: assert property (p_noise_dark)
      else $error("noise fault not dark");
   property p_sys_h;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (sys_q && !noise_q && !short_q) |=>
         (ind_o.module_health_indicator == SECL_LED_RED &&
          ind_o.digit_left == SECL_CH_H);
   endproperty
   a_sys_h: assert property (p_sys_h)
      else $error("system failure indication wrong");
   property p_short_p6;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (short_q && !noise_q) |=> (ind_o.digit_left == SECL_CH_P &&
                                 ind_o.digit_right == SECL_CH_6);
   endproperty
   a_short_p6: assert property (p_short_p6)
      else $error("short code not shown");
   property p_old_unit;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (fault_i.out_short && unit_version_i < SECL_VER_SHORT_MIN && !short_q)
         |=> !short_q && sys_q;
   endproperty
   a_old_unit: assert property (p_old_unit)
      else $error("old unit produced short code");
   sequence s_mis_trig;
      switch_changed_i && download_done_i && !mis_q && !sys_q &&
         !short_q && !noise_q;
   endsequence
   property p_mis_log;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      s_mis_trig ##0 !(fault_i.sys_fail || fault_i.out_short) |=>
         (hist_o.wr && hist_o.code == SECL_HIST_SWMIS && mis_q);
   endproperty
   a_mis_log: assert property (p_mis_log)
      else $error("mismatch not logged");
   property p_mis_abort;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (mis_q && !noise_q && !sys_q && !short_q) |-> cls == SECL_CLS_ABORT;
   endproperty
   a_mis_abort: assert property (p_mis_abort)
      else $error("mismatch not abort");
   property p_rank;
      @(posedge sys_clk_i) disable iff (!nrst_i)
      (noise_q || sys_q || short_q) |=> class_o == SECL_CLS_CRITICAL;
   endproperty
   a_rank: assert property (p_rank)
      else $error("severity ranking wrong");
endmodule

/* verilog/secl_pkg.sv */
package secl_pkg;
   // indicator colour / pattern codes
   typedef enum logic [1:0] {
      SECL_LED_OFF,
      SECL_LED_RED,
      SECL_LED_RED_FLASH,
      SECL_LED_GREEN
   } secl_led_t;

   // error class, ordered by rising severity
   typedef enum logic [1:0] {
      SECL_CLS_NONE,
      SECL_CLS_NONFATAL,
      SECL_CLS_ABORT,
      SECL_CLS_CRITICAL
   } secl_cls_t;

   // history codes written to nonvolatile log
   localparam logic [7:0] SECL_HIST_SYSFAIL = 8'h01;
   localparam logic [7:0] SECL_HIST_SWMIS = 8'h02;

   // seven-segment character codes (ascii-like)
   localparam logic [7:0] SECL_CH_BLANK = 8'h00;
   localparam logic [7:0] SECL_CH_H = 8'h48;
   localparam logic [7:0] SECL_CH_P = 8'h50;
   localparam logic [7:0] SECL_CH_6 = 8'h36;
   localparam logic [7:0] SECL_CH_E = 8'h45;
   localparam logic [7:0] SECL_CH_8 = 8'h38;

   // unit version 1.0 expressed as major.minor nibbles
   localparam logic [7:0] SECL_VER_SHORT_MIN = 8'h10;

   // display alternate and flash periods
   localparam int SECL_CLK_HZ = 25000000;
   localparam int SECL_ALT_MS = 1000;
   localparam int SECL_ALT_CYC = SECL_CLK_HZ / 1000 * SECL_ALT_MS;
   localparam int SECL_FLASH_MS = 500;
   localparam int SECL_FLASH_CYC = SECL_CLK_HZ / 1000 * SECL_FLASH_MS;

   // fault inputs, one bit each
   typedef struct packed {
      logic noise_hw;
      logic sys_fail;
      logic out_short;
      logic sw_mismatch;
      logic abort_other;
   } secl_fault_t;

   // indicator and display outputs
   typedef struct packed {
      secl_led_t module_health_indicator;
      secl_led_t network_health_indicator;
      logic [7:0] digit_left;
      logic [7:0] digit_right;
   } secl_ind_t;

   typedef struct packed {
      logic wr;
      logic [7:0] code;
      logic [7:0] node;
   } secl_hist_t;
endpackage

/* verilog/secl_tick.sv */
`timescale 1ns/1ps
module secl_tick #(
   parameter int PERIOD = 1000
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   output logic tick_o
);
   logic [31:0] cnt_q;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= 32'h0;
         tick_o <= 1'b0;
      end else if (cnt_q == 32'(PERIOD - 1)) begin
         cnt_q <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule

/* verif/secl_tool_model.sv */
`timescale 1ns/1ps
module secl_tool_model (
   input wire logic sys_clk_i,
   input wire secl_pkg::secl_hist_t hist_i,
   output logic [7:0] log_cnt_o,
   output logic [7:0] last_code_o,
   output logic [7:0] last_node_o
);
   import secl_pkg::*;
   // the tool's copy of the log survives device resets
   initial begin
      log_cnt_o = 8'h00;
      last_code_o = 8'h00;
      last_node_o = 8'h00;
   end
   always @(posedge sys_clk_i) begin
      if (hist_i.wr === 1'b1) begin
         log_cnt_o <= log_cnt_o + 8'h01;
         last_code_o <= hist_i.code;
         last_node_o <= hist_i.node;
      end
   end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
   import secl_pkg::*;
   logic sys_clk_i, nrst_i, download_done_i, switch_changed_i, clear_i;
   secl_fault_t fault_i;
   logic [7:0] conn_fault_i, node_addr_i, unit_version_i, conn_safe_o;
   secl_cls_t class_o;
   logic safety_run_o, all_run_o, msg_enable_o, tool_enable_o;
   secl_ind_t ind_o;
   secl_hist_t hist_o;
   logic [7:0] log_cnt, last_code, last_node, base;
   int miscompares, tests_run, cycles;
   int nflash, noff, ne8, nnode;
   secl_classifier #(.N_CONN(8), .ALT_CYC(4), .FLASH_CYC(2)) DUT (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .fault_i(fault_i),
      .conn_fault_i(conn_fault_i), .download_done_i(download_done_i),
      .switch_changed_i(switch_changed_i), .node_addr_i(node_addr_i),
      .unit_version_i(unit_version_i), .clear_i(clear_i),
      .class_o(class_o), .conn_safe_o(conn_safe_o),
      .safety_run_o(safety_run_o), .all_run_o(all_run_o),
      .msg_enable_o(msg_enable_o), .tool_enable_o(tool_enable_o),
      .ind_o(ind_o), .hist_o(hist_o));
   secl_tool_model tool (.sys_clk_i(sys_clk_i), .hist_i(hist_o),
      .log_cnt_o(log_cnt), .last_code_o(last_code),
      .last_node_o(last_node));
   ////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic do_reset();
      nrst_i = 1'b0;
      fault_i = '0;
      conn_fault_i = 8'h00;
      download_done_i = 1'b0;
      switch_changed_i = 1'b0;
      clear_i = 1'b0;
      step(3);
      nrst_i = 1'b1;
      step(1);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic test_nonfatal();
      chk(class_o, SECL_CLS_NONE);
      chk(conn_safe_o, 8'h00);
      chk(ind_o, {SECL_LED_GREEN, SECL_LED_GREEN, 16'h0000});
      conn_fault_i = 8'h08;
      step(3);
      chk(class_o, SECL_CLS_NONFATAL);
      chk(conn_safe_o, 8'h08);
      chk({safety_run_o, all_run_o}, 2'b11);
      conn_fault_i = 8'h00;
      $display("test nonfatal done");
   endtask
   task automatic test_abort();
      conn_fault_i = 8'h01;
      fault_i.abort_other = 1'b1;
      step(1);
      fault_i.abort_other = 1'b0;
      step(3);
      chk(class_o, SECL_CLS_ABORT);
      chk(conn_safe_o, 8'hff);
      chk({safety_run_o, all_run_o}, 2'b01);
      chk({msg_enable_o, tool_enable_o}, 2'b11);
      conn_fault_i = 8'h00;
      clear_i = 1'b1;
      step(1);
      clear_i = 1'b0;
      step(3);
      chk(class_o, SECL_CLS_NONE);
      $display("test abort done");
   endtask
   task automatic test_mismatch();
      base = log_cnt;
      node_addr_i = 8'h5a;
      switch_changed_i = 1'b1;
      step(4);
      chk(class_o, SECL_CLS_NONE);
      chk(log_cnt, base);
      download_done_i = 1'b1;
      step(3);
      chk(class_o, SECL_CLS_ABORT);
      chk(log_cnt, base + 8'h01);
      chk({last_code, last_node}, {SECL_HIST_SWMIS, 8'h5a});
      nflash = 0;
      noff = 0;
      ne8 = 0;
      nnode = 0;
      repeat (12) begin
         step(1);
         if (ind_o.module_health_indicator === SECL_LED_RED_FLASH) nflash++;
         if (ind_o.module_health_indicator === SECL_LED_OFF) noff++;
         if (ind_o.digit_left === SECL_CH_E) begin
            if (ind_o.digit_right === SECL_CH_8) ne8++;
         end else if (ind_o.digit_left === 8'h05 &&
                      ind_o.digit_right === 8'h0a) begin
            nnode++;
         end
      end
      chk({nflash != 0, noff != 0}, 2'b11);
      chk({ne8 != 0, nnode != 0}, 2'b11);
      switch_changed_i = 1'b0;
      clear_i = 1'b1;
      step(1);
      clear_i = 1'b0;
      step(2);
      chk(class_o, SECL_CLS_NONE);
      do_reset();
      $display("test mismatch done");
   endtask
   task automatic test_sysfail();
      base = log_cnt;
      fault_i.sys_fail = 1'b1;
      step(1);
      fault_i.sys_fail = 1'b0;
      fault_i.abort_other = 1'b1;
      clear_i = 1'b1;
      step(3);
      chk(class_o, SECL_CLS_CRITICAL);
      chk({safety_run_o, all_run_o, msg_enable_o}, 3'b000);
      chk({ind_o.module_health_indicator, ind_o.network_health_indicator,
         ind_o.digit_left}, {SECL_LED_RED, SECL_LED_OFF, SECL_CH_H});
      chk({log_cnt, last_code}, {base + 8'h01, SECL_HIST_SYSFAIL});
      do_reset();
      $display("test system failure done");
   endtask
   task automatic test_short();
      unit_version_i = SECL_VER_SHORT_MIN;
      fault_i.out_short = 1'b1;
      step(4);
      chk(class_o, SECL_CLS_CRITICAL);
      chk(ind_o, {SECL_LED_RED, SECL_LED_OFF, SECL_CH_P, SECL_CH_6});
      do_reset();
      unit_version_i = 8'h0f;
      fault_i.out_short = 1'b1;
      step(4);
      chk(ind_o.digit_left, SECL_CH_H);
      do_reset();
      $display("test output short done");
   endtask
   task automatic test_noise();
      base = log_cnt;
      fault_i.noise_hw = 1'b1;
      step(1);
      fault_i.noise_hw = 1'b0;
      step(3);
      chk({class_o, all_run_o}, {SECL_CLS_CRITICAL, 1'b0});
      chk(ind_o, 20'h00000);
      chk(log_cnt, base);
      do_reset();
      $display("test noise done");
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      miscompares = 0;
      tests_run = 0;
      cycles = 0;
      node_addr_i = 8'h00;
      unit_version_i = SECL_VER_SHORT_MIN;
      #1;
      do_reset();
      test_nonfatal();
      test_abort();
      test_mismatch();
      test_sysfail();
      test_short();
      test_noise();
      final_report();
   end
endmodule
